//--- rtl/stpdrv_device.sv
// Driver end: serial port, word registers, PWM timing and bridge gating.
// Assumes serial pins synchronous to clk_i and an external oscillator pin.
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "stpdrv_defines.svh"
module stpdrv_device (
   input wire logic clk_i,
   input wire logic srst_i,
   stpdrv_if.drv link,
   input wire logic sleep_n_i,
   input wire logic uvlo_i,
   input wire logic osc_ext_i,
   input wire logic [1:0] trip_i,
   output logic [1:0] bridge_a_o,
   output logic [1:0] bridge_b_o,
   output logic [1:0] sink_chop_o,
   output logic [1:0] fast_decay_o,
   output logic [5:0] dac1_o,
   output logic [5:0] dac2_o,
   output logic ext_ref_o,
   output logic range_div4_o,
   output logic [1:0] sync_rectifier_select_o,
   output logic pump_en_o,
   output logic master_timing_clock_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Serial port and word registers.
   logic [18:0] shift_r, shift_nxt; // Incoming shift register.
   logic [18:0] word0_r, word0_nxt; // Current and phase word.
   logic [18:0] word1_r, word1_nxt; // Timing word.
   logic sclk_q_r, stb_q_r; // Previous pin levels for edges.
   logic clr; // Port clear from sleep or undervoltage.
   assign clr = !sleep_n_i || uvlo_i;

   // Shift on rising serial clock while strobe is low; latch on strobe rise.
   always_comb begin
      shift_nxt = shift_r;
      word0_nxt = word0_r;
      word1_nxt = word1_r;
      if (clr) begin
         shift_nxt = `STPDRV_WORD_RST;
         word0_nxt = `STPDRV_WORD_RST;
         word1_nxt = `STPDRV_WORD_RST;
      end else begin
         if (!link.strobe_n && link.sclk && !sclk_q_r) begin
            shift_nxt = {shift_r[17:0], link.sdata};
         end
         if (link.strobe_n && !stb_q_r) begin
            if (shift_r[`STPDRV_SEL_BIT]) begin
               word1_nxt = shift_r;
            end else begin
               word0_nxt = shift_r;
            end
         end
      end
   end

   // Register the serial state.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         shift_r <= `STPDRV_WORD_RST;
         word0_r <= `STPDRV_WORD_RST;
         word1_r <= `STPDRV_WORD_RST;
         sclk_q_r <= 1'b0;
         stb_q_r <= 1'b1;
      end else begin
         shift_r <= shift_nxt;
         word0_r <= word0_nxt;
         word1_r <= word1_nxt;
         sclk_q_r <= link.sclk;
         stb_q_r <= link.strobe_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Master oscillator enable.
   logic [2:0] idiv_r, idiv_nxt; // Internal 4 MHz divider.
   logic [1:0] ediv_r, ediv_nxt; // External clock divider.
   logic ext_q_r; // Previous external oscillator level.
   logic ext_rise, mo_tick, mo_tog_r, mo_tog_nxt;
   assign ext_rise = osc_ext_i && !ext_q_r;

   // Choose the timing tick from the oscillator field.
   always_comb begin
      idiv_nxt = (idiv_r == 3'(`STPDRV_INT_DIV - 1)) ? 3'h0 : idiv_r + 3'h1;
      ediv_nxt = ext_rise ? ediv_r + 2'h1 : ediv_r;
      case (word1_r[`STPDRV_W1_OSC_LSB +: 2])
         2'h0: mo_tick = (idiv_r == 3'h0);
         2'h1: mo_tick = ext_rise;
         2'h2: mo_tick = ext_rise && ediv_r[0];
         default: mo_tick = ext_rise && (ediv_r == 2'h3);
      endcase
      mo_tog_nxt = mo_tick ? !mo_tog_r : mo_tog_r;
   end

   // Register the oscillator state.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         idiv_r <= 3'h0;
         ediv_r <= 2'h0;
         ext_q_r <= 1'b0;
         mo_tog_r <= 1'b0;
      end else begin
         idiv_r <= idiv_nxt;
         ediv_r <= ediv_nxt;
         ext_q_r <= osc_ext_i;
         mo_tog_r <= mo_tog_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-bridge PWM off-time, fast-decay and blanking timers.
   logic idle; // Idle mode when the idle bit is zero.
   logic [7:0] off_len, fast_len, blank_len; // Lengths in oscillator periods.
   assign idle = !word1_r[`STPDRV_W1_IDLE_BIT];
   assign off_len = 8'(({3'h0, word1_r[`STPDRV_W1_OFF_LSB +: 5]} + 8'h1) * 8'h8 - 8'h1);
   assign fast_len = 8'(({4'h0, word1_r[`STPDRV_W1_FAST_LSB +: 4]} + 8'h1) * 8'h8 - 8'h1);

   // Blank length from the two-bit field.
   always_comb begin
      case (word1_r[`STPDRV_W1_BLANK_LSB +: 2])
         2'h0: blank_len = `STPDRV_BLANK_0;
         2'h1: blank_len = `STPDRV_BLANK_1;
         2'h2: blank_len = `STPDRV_BLANK_2;
         default: blank_len = `STPDRV_BLANK_3;
      endcase
   end

   logic [1:0] a_nxt, b_nxt, sink_nxt, fast_nxt;
   logic [1:0] en_b; // Bridge enable: nonzero code, not idle and no port clear.
   genvar g;
   for (g = 0; g < 2; g++) begin : g_br
      stpdrv_pkg::stpdrv_pwm_t st_r, st_nxt;
      logic [7:0] cnt_r, cnt_nxt; // Periods elapsed in the off time or the blank time.
      logic ph_q_r; // Previous phase bit.
      logic ph, slow, on_drv;
      logic [5:0] code;
      assign code = word0_r[(g == 0 ? `STPDRV_W0_DAC1_LSB : `STPDRV_W0_DAC2_LSB) +: 6];
      assign ph = word0_r[`STPDRV_W0_PH1_BIT + g];
      assign slow = word0_r[`STPDRV_W0_MODE1_BIT + g];
      assign en_b[g] = (code != 6'h00) && !idle && !clr;

      // Off-time sequencer: trip starts off time, blanking follows it.
      always_comb begin
         st_nxt = st_r;
         cnt_nxt = cnt_r;
         if (!en_b[g]) begin
            st_nxt = stpdrv_pkg::STPDRV_ON;
            cnt_nxt = 8'h00;
         end else if (ph != ph_q_r) begin
            st_nxt = stpdrv_pkg::STPDRV_BLANK;
            cnt_nxt = 8'h00;
         end else begin
            case (st_r)
               stpdrv_pkg::STPDRV_ON: begin
                  if (trip_i[g]) begin
                     st_nxt = slow ? stpdrv_pkg::STPDRV_SLOW : stpdrv_pkg::STPDRV_FAST;
                     cnt_nxt = 8'h00;
                  end
               end
               stpdrv_pkg::STPDRV_FAST, stpdrv_pkg::STPDRV_SLOW: begin
                  if (mo_tick) begin
                     cnt_nxt = cnt_r + 8'h1;
                     if (cnt_r + 8'h1 >= off_len) begin
                        st_nxt = stpdrv_pkg::STPDRV_BLANK;
                        cnt_nxt = 8'h00;
                     end else if (cnt_r + 8'h1 >= fast_len) begin
                        st_nxt = stpdrv_pkg::STPDRV_SLOW;
                     end
                  end
               end
               stpdrv_pkg::STPDRV_BLANK: begin
                  if (mo_tick) begin
                     cnt_nxt = cnt_r + 8'h1;
                     if (cnt_r + 8'h1 >= blank_len) begin
                        st_nxt = stpdrv_pkg::STPDRV_ON;
                        cnt_nxt = 8'h00;
                     end
                  end
               end
               default: begin
                  st_nxt = stpdrv_pkg::STPDRV_ON;
                  cnt_nxt = 8'h00;
               end
            endcase
         end
         // Bridge drive: source on except in off time; trips ignored in blanking.
         on_drv = (st_r == stpdrv_pkg::STPDRV_ON) || (st_r == stpdrv_pkg::STPDRV_BLANK);
         a_nxt[g] = en_b[g] && on_drv && ph;
         b_nxt[g] = en_b[g] && on_drv && !ph;
         sink_nxt[g] = en_b[g] && !on_drv &&
            (word1_r[`STPDRV_W1_SR_LSB +: 2] == 2'h3);
         fast_nxt[g] = en_b[g] && (st_r == stpdrv_pkg::STPDRV_FAST);
      end

      // Register the bridge timer.
      always_ff @(posedge clk_i) begin
         if (srst_i) begin
            st_r <= stpdrv_pkg::STPDRV_ON;
            cnt_r <= 8'h00;
            ph_q_r <= 1'b0;
         end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            ph_q_r <= ph;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output registers.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bridge_a_o <= 2'h0;
         bridge_b_o <= 2'h0;
         sink_chop_o <= 2'h0;
         fast_decay_o <= 2'h0;
         dac1_o <= 6'h00;
         dac2_o <= 6'h00;
         ext_ref_o <= 1'b0;
         range_div4_o <= 1'b0;
         sync_rectifier_select_o <= 2'h0;
         pump_en_o <= 1'b0;
         master_timing_clock_o <= 1'b0;
      end else begin
         bridge_a_o <= a_nxt;
         bridge_b_o <= b_nxt;
         sink_chop_o <= sink_nxt;
         fast_decay_o <= fast_nxt;
         dac1_o <= word0_r[`STPDRV_W0_DAC1_LSB +: 6];
         dac2_o <= word0_r[`STPDRV_W0_DAC2_LSB +: 6];
         ext_ref_o <= word0_r[`STPDRV_W0_REF_BIT];
         range_div4_o <= word0_r[`STPDRV_W0_RANGE_BIT];
         sync_rectifier_select_o <= word1_r[`STPDRV_W1_SR_LSB +: 2];
         pump_en_o <= !idle && !clr;
         master_timing_clock_o <= mo_tog_r;
      end
   end
endmodule
`default_nettype wire

//--- shared/stpdrv_defines.svh
// Constants for the serial-programmed stepper driver control logic.
// Assumes inclusion by bare name from shared/; definitions only.
`ifndef STPDRV_DEFINES_SVH
`define STPDRV_DEFINES_SVH
// Serial word layout.
`define STPDRV_WORD_W 19
`define STPDRV_SEL_BIT 0
`define STPDRV_W0_DAC1_LSB 1
`define STPDRV_W0_DAC2_LSB 7
`define STPDRV_W0_PH1_BIT 13
`define STPDRV_W0_PH2_BIT 14
`define STPDRV_W0_MODE1_BIT 15
`define STPDRV_W0_MODE2_BIT 16
`define STPDRV_W0_REF_BIT 17
`define STPDRV_W0_RANGE_BIT 18
`define STPDRV_W1_BLANK_LSB 1
`define STPDRV_W1_OFF_LSB 3
`define STPDRV_W1_FAST_LSB 8
`define STPDRV_W1_OSC_LSB 12
`define STPDRV_W1_SR_LSB 14
`define STPDRV_W1_IDLE_BIT 18
// Reset value of both words.
`define STPDRV_WORD_RST 19'h0_0000
// Blank times in master oscillator periods.
`define STPDRV_BLANK_0 8'h04
`define STPDRV_BLANK_1 8'h06
`define STPDRV_BLANK_2 8'h08
`define STPDRV_BLANK_3 8'h0C
// Internal oscillator divider: 20 MHz system clock to 4 MHz.
`define STPDRV_CLK_HZ 20000000
`define STPDRV_INT_OSC_HZ 4000000
`define STPDRV_INT_DIV (`STPDRV_CLK_HZ / `STPDRV_INT_OSC_HZ)
// Host serial clock half period in system cycles, meets 40 ns widths.
`define STPDRV_SCLK_HALF 4
// Host strobe setup and hold in system cycles, 150 ns at 50 ns period.
`define STPDRV_STB_NS 150
`define STPDRV_CLK_NS 50
`define STPDRV_STB_CYC ((`STPDRV_STB_NS + `STPDRV_CLK_NS - 1) / `STPDRV_CLK_NS)
// Host register offsets, byte addresses.
`define STPDRV_REG_DATA 4'h0
`define STPDRV_REG_CTRL 4'h4
`define STPDRV_REG_STAT 4'h8
`endif

//--- shared/stpdrv_pkg.sv
// Types for the stepper driver control logic.
// Assumes nothing beyond a SystemVerilog compiler.
package stpdrv_pkg;
   // Decay phase of one bridge during a PWM cycle.
   typedef enum logic [3:0] {
      STPDRV_ON = 4'b0001,
      STPDRV_FAST = 4'b0010,
      STPDRV_SLOW = 4'b0100,
      STPDRV_BLANK = 4'b1000
   } stpdrv_pwm_t;
   // Host serial sender state.
   typedef enum logic [3:0] {
      STPDRV_H_IDLE = 4'b0001,
      STPDRV_H_SETUP = 4'b0010,
      STPDRV_H_SHIFT = 4'b0100,
      STPDRV_H_HOLD = 4'b1000
   } stpdrv_host_t;
endpackage

//--- shared/stpdrv_if.sv
// Three-wire serial link between the controller and the driver logic.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface stpdrv_if;
   logic sclk; // Serial clock, data taken on rising edge.
   logic sdata; // Serial data, most significant bit first.
   logic strobe_n; // Strobe, rests high, low during a write.
   modport ctrl (output sclk, output sdata, output strobe_n);
   modport drv (input sclk, input sdata, input strobe_n);
endinterface
`default_nettype wire

//--- rtl/stpdrv_host.sv
// Controller end: Avalon-MM registers and a serial word sender.
// Assumes the device end samples the link on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "stpdrv_defines.svh"
module stpdrv_host (
   input wire logic clk_i,
   input wire logic srst_i,
   stpdrv_if.ctrl link,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Registers and sender state.
   logic [18:0] data_r, data_nxt; // Word to send.
   logic [18:0] sh_r, sh_nxt; // Shift copy.
   logic [4:0] bit_r, bit_nxt; // Bits left.
   logic [3:0] tm_r, tm_nxt; // Phase timer.
   logic sclk_r, sclk_nxt, sd_r, sd_nxt, stb_r, stb_nxt;
   logic [31:0] rd_nxt;
   logic wait_nxt, busy;
   stpdrv_pkg::stpdrv_host_t st_r, st_nxt;
   assign busy = (st_r != stpdrv_pkg::STPDRV_H_IDLE);
   assign link.sclk = sclk_r;
   assign link.sdata = sd_r;
   assign link.strobe_n = stb_r;

   // Bus answer one cycle after a request; sender runs the frame.
   always_comb begin
      data_nxt = data_r;
      sh_nxt = sh_r;
      bit_nxt = bit_r;
      tm_nxt = tm_r;
      sclk_nxt = sclk_r;
      sd_nxt = sd_r;
      stb_nxt = stb_r;
      st_nxt = st_r;
      rd_nxt = avs_readdata_o;
      wait_nxt = 1'b1;
      if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
         wait_nxt = 1'b0;
         rd_nxt = 32'h0000_0000;
         case (avs_address_i)
            `STPDRV_REG_DATA: rd_nxt = {13'h0000, data_r};
            `STPDRV_REG_STAT: rd_nxt = {31'h0000_0000, busy};
            default: rd_nxt = 32'h0000_0000;
         endcase
         if (avs_write_i && avs_address_i == `STPDRV_REG_DATA && !busy) begin
            data_nxt = avs_writedata_i[18:0];
         end
         if (avs_write_i && avs_address_i == `STPDRV_REG_CTRL && avs_writedata_i[0] && !busy) begin
            sh_nxt = data_r;
            bit_nxt = 5'd19;
            stb_nxt = 1'b0;
            tm_nxt = 4'(`STPDRV_STB_CYC);
            st_nxt = stpdrv_pkg::STPDRV_H_SETUP;
         end
      end
      case (st_r)
         stpdrv_pkg::STPDRV_H_IDLE: begin
         end
         stpdrv_pkg::STPDRV_H_SETUP, stpdrv_pkg::STPDRV_H_SHIFT: begin
            if (tm_r != 4'h0) begin
               tm_nxt = tm_r - 4'h1;
            end else if (!sclk_r && bit_r != 5'd0) begin
               sd_nxt = sh_r[18];
               sh_nxt = {sh_r[17:0], 1'b0};
               sclk_nxt = 1'b0;
               tm_nxt = 4'(`STPDRV_SCLK_HALF);
               st_nxt = stpdrv_pkg::STPDRV_H_SHIFT;
               if (st_r == stpdrv_pkg::STPDRV_H_SHIFT) begin
                  sclk_nxt = 1'b1;
                  sh_nxt = sh_r;
                  sd_nxt = sd_r;
                  bit_nxt = bit_r - 5'd1;
                  st_nxt = stpdrv_pkg::STPDRV_H_HOLD;
               end
            end else begin
               st_nxt = stpdrv_pkg::STPDRV_H_HOLD;
            end
         end
         stpdrv_pkg::STPDRV_H_HOLD: begin
            if (tm_r != 4'h0) begin
               tm_nxt = tm_r - 4'h1;
            end else if (sclk_r) begin
               sclk_nxt = 1'b0;
               tm_nxt = (bit_r == 5'd0) ? 4'(`STPDRV_STB_CYC) : 4'(`STPDRV_SCLK_HALF);
               st_nxt = (bit_r == 5'd0) ? stpdrv_pkg::STPDRV_H_HOLD : stpdrv_pkg::STPDRV_H_SETUP;
            end else begin
               stb_nxt = 1'b1;
               st_nxt = stpdrv_pkg::STPDRV_H_IDLE;
            end
         end
         default: st_nxt = stpdrv_pkg::STPDRV_H_IDLE;
      endcase
   end

   // Register everything.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         data_r <= 19'h0_0000;
         sh_r <= 19'h0_0000;
         bit_r <= 5'd0;
         tm_r <= 4'h0;
         sclk_r <= 1'b0;
         sd_r <= 1'b0;
         stb_r <= 1'b1;
         st_r <= stpdrv_pkg::STPDRV_H_IDLE;
         avs_readdata_o <= 32'h0000_0000;
         avs_waitrequest_o <= 1'b1;
      end else begin
         data_r <= data_nxt;
         sh_r <= sh_nxt;
         bit_r <= bit_nxt;
         tm_r <= tm_nxt;
         sclk_r <= sclk_nxt;
         sd_r <= sd_nxt;
         stb_r <= stb_nxt;
         st_r <= st_nxt;
         avs_readdata_o <= rd_nxt;
         avs_waitrequest_o <= wait_nxt;
      end
   end
endmodule
`default_nettype wire

//--- verification/stpdrv_link_checker.sv
// Checker for the three-wire link between controller and driver ends.
// Assumes the link signals change only just after rising edges of clk_i.
`timescale 1ns/1ps
`default_nettype none
module stpdrv_link_checker (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic strobe_n
);
   ////////////////////////////////////////////////////////////////////////
   logic [5:0] bit_cnt_r; // Serial clock rises seen in the open frame.
   logic [5:0] bit_cnt_nxt; // Next value of the rise count.
   logic sclk_d_r; // Serial clock one cycle late, finds rises.
   // A rise inside a frame adds one; an idle strobe restarts the count.
   always_comb begin
      bit_cnt_nxt = bit_cnt_r;
      if (strobe_n) begin
         bit_cnt_nxt = 6'h00;
      end else if (sclk && !sclk_d_r) begin
         bit_cnt_nxt = bit_cnt_r + 6'h01;
      end
   end
   // Registers the count and the delayed clock.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bit_cnt_r <= 6'h00;
         sclk_d_r <= 1'b0;
      end else begin
         bit_cnt_r <= bit_cnt_nxt;
         sclk_d_r <= sclk;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking dflt @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence s_open; $fell(strobe_n); endsequence
   sequence s_close; $rose(strobe_n); endsequence
   property p_idle_low; strobe_n |-> !sclk; endproperty
   property p_rise_framed; $rose(sclk) |-> !strobe_n; endproperty
   property p_count; s_close |-> bit_cnt_r == 6'h13; endproperty
   property p_data_stable; sclk |-> $stable(sdata); endproperty
   property p_setup; s_open |-> !sclk [*3]; endproperty
   property p_high_width; $rose(sclk) |-> sclk [*4]; endproperty
   property p_low_width; $fell(sclk) |-> !sclk [*3]; endproperty
   property p_strobe_min; s_open |-> !strobe_n [*8]; endproperty
   property p_frame_len; s_open |-> ##[120:400] s_close; endproperty
   a_idle_low: assert property (p_idle_low) else $error("clock moved outside frame");
   a_rise_framed: assert property (p_rise_framed) else $error("rise with strobe high");
   a_count: assert property (p_count) else $error("frame bit count wrong");
   a_data_stable: assert property (p_data_stable) else $error("data moved in clock high");
   a_setup: assert property (p_setup) else $error("strobe setup short");
   a_high_width: assert property (p_high_width) else $error("clock high too short");
   a_low_width: assert property (p_low_width) else $error("clock low too short");
   a_strobe_min: assert property (p_strobe_min) else $error("strobe pulse too short");
   a_frame_len: assert property (p_frame_len) else $error("frame did not close");
endmodule
`default_nettype wire

//--- verification/stpdrv_bench.sv
// Self-checking bench joining controller and driver ends over the link.
// Assumes one 20 MHz clock; a word model predicts the configuration and bridge source outputs.
`timescale 1ns/1ps
`default_nettype none
module stpdrv_bench;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic sleep_n = 1'b1; // Sleep input, low clears the port.
   logic uvlo = 1'b0; // Undervoltage input, high clears the port.
   logic osc_ext = 1'b0; // Free-running external oscillator.
   logic [1:0] oc = 2'b00; // Divider making osc_ext at clk/4.
   logic [1:0] trip = 2'b00;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata, rq;
   logic wait_req, ext_ref, div4, pump, mtc;
   logic [1:0] br_a, br_b, chop, fast, sr_sel;
   logic [5:0] dac1, dac2;
   int error_cnt = 0;
   int comparisons = 0;
   int blk[4] = '{4, 6, 8, 12}; // Blank ticks per code.
   int tb[4][4] = '{'{0, 0, 0, 0}, '{1, 0, 1, 1}, '{0, 15, 2, 2}, '{0, 0, 3, 3}};
   logic [18:0] w0 = 19'h0_0000; // Model of both words.
   logic [18:0] w1 = 19'h0_0000;
   logic [18:0] exp_q[$]; // Words expected on the wire.
   logic sclk_q = 1'b0;
   logic strb_q = 1'b1;
   logic [18:0] sh = 19'h0_0000;
   int nbits = 0;
   stpdrv_if link ();
   stpdrv_host stpdrv_host_i (.clk_i(clk_i), .srst_i(srst_i), .link(link),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req));
   stpdrv_device stpdrv_device_i (.clk_i(clk_i), .srst_i(srst_i), .link(link),
      .sleep_n_i(sleep_n), .uvlo_i(uvlo), .osc_ext_i(osc_ext), .trip_i(trip),
      .bridge_a_o(br_a), .bridge_b_o(br_b), .sink_chop_o(chop), .fast_decay_o(fast),
      .dac1_o(dac1), .dac2_o(dac2), .ext_ref_o(ext_ref), .range_div4_o(div4),
      .sync_rectifier_select_o(sr_sel), .pump_en_o(pump), .master_timing_clock_o(mtc));
   stpdrv_link_checker stpdrv_link_checker_i (.clk_i(clk_i), .srst_i(srst_i),
      .sclk(link.sclk), .sdata(link.sdata), .strobe_n(link.strobe_n));
   ////////////////////////////////////////////////////////////////////////
   // Clock and the external oscillator.
   initial forever #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      oc <= oc + 2'b01;
      osc_ext <= oc[1];
   end
   // Counts every comparison and reports a mismatch at once.
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %0h got %0h", n, e, g);
      end
   endtask
   // Tick counts may land up to t ticks off through oscillator alignment.
   task automatic near(input string n, input int e, input int g, input int t);
      chk(n, e, (g >= e - t && g <= e + t) ? e : g);
   endtask
   // Watches the wire and rebuilds each frame in arrival order.
   always @(posedge clk_i) begin
      sclk_q <= link.sclk;
      strb_q <= link.strobe_n;
      if (!srst_i && !link.strobe_n && link.sclk && !sclk_q) begin
         sh <= {sh[17:0], link.sdata};
         nbits <= nbits + 1;
      end
      if (!srst_i && link.strobe_n && !strb_q) begin
         chk("frame", exp_q.pop_front(), sh);
         chk("bits", 19, nbits);
         nbits <= 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // One Avalon transfer, held until waitrequest is seen low.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wait_req !== 1'b0 && n < 50);
      rq = rdata;
      if (n >= 50) chk("waitrequest", 0, 1);
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_i);
   endtask
   // Sends one word and waits until the sender is idle again.
   task automatic send(input logic [18:0] w);
      int n;
      n = 0;
      bus(1'b1, 4'h0, 32'(w));
      exp_q.push_back(w);
      bus(1'b1, 4'h4, 32'h0000_0001);
      do begin
         bus(1'b0, 4'h8, 32'h0000_0000);
         n++;
      end while (rq[0] !== 1'b0 && n < 200);
      // A sender that never goes idle is a failure, not a silent pass.
      if (n >= 200) chk("busy", 0, 1);
      repeat (4) @(posedge clk_i);
      if (w[0]) w1 = w;
      else w0 = w;
   endtask
   // Compares every configuration output with the word model.
   task automatic check_cfg();
      logic on;
      chk("dac1", w0[6:1], dac1);
      chk("dac2", w0[12:7], dac2);
      chk("ext_ref", w0[17], ext_ref);
      chk("div4", w0[18], div4);
      chk("sr_sel", w1[15:14], sr_sel);
      chk("pump", w1[18], pump);
      for (int i = 0; i < 2; i++) begin
         on = w1[18] && ((i != 0) ? w0[12:7] : w0[6:1]) != 6'h00;
         chk("src_a", on & w0[13 + i], br_a[i]);
         chk("src_b", on & !w0[13 + i], br_b[i]);
      end
   endtask
   // Holds a trip on bridge 1, then times one off period and one blank.
   task automatic pwm(input int mode, input int nf, input int bl, input int sr);
      int off_t, fast_t, on_t, sc, st;
      logic m, off, tk;
      off_t = 0;
      fast_t = 0;
      on_t = 0;
      sc = 0;
      st = 0;
      send(19'(19'h4_0009 | (sr << 14) | (nf << 8) | (bl << 1)));
      send(19'(19'h0_2082 | (mode << 15)));
      trip <= 2'b01;
      m = mtc;
      for (int n = 0; n < 1000 && st < 3; n++) begin
         @(posedge clk_i);
         off = br_a[0] === 1'b0 && br_b[0] === 1'b0;
         tk = mtc !== m;
         m = mtc;
         if (st == 0 && off) st = 1;
         else if (st == 1 && !off) st = 2;
         else if (st == 2 && off) st = 3;
         if (st == 1) begin
            off_t += tk;
            fast_t += tk & fast[0];
            sc |= chop[0];
         end
         if (st == 2) on_t += tk;
      end
      trip <= 2'b00;
      near("off_ticks", 15, off_t, 1);
      near("fast_ticks", mode ? 0 : (nf ? 15 : 7), fast_t, 1);
      near("blank_ticks", blk[bl], on_t, 1);
      chk("sink_chop", sr == 3, sc);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then stops the run.
   task automatic close_out();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (60000) @(posedge clk_i);
      error_cnt++;
      close_out();
   end
   // Main sequence.
   initial begin
      int t;
      void'($urandom(32'h1554));
      repeat (3) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check_cfg();
      chk("strobe_rest", 1, link.strobe_n);
      bus(1'b1, 4'h0, 32'h0000_1235);
      bus(1'b0, 4'h0, 32'h0000_0000);
      chk("data_rb", 32'h0000_1235, rq);
      bus(1'b0, 4'hC, 32'h0000_0000);
      chk("unmapped", 0, rq);
      // Idle bit goes high once and stays high for 1 ms before any code enables a bridge.
      send(19'h4_0001);
      repeat (20000) @(posedge clk_i);
      for (int k = 0; k < 4; k++) pwm(tb[k][0], tb[k][1], tb[k][2], tb[k][3]);
      for (int c = 0; c < 4; c++) begin
         send(19'(19'h4_0001 | (c << 12)));
         // Lets the new oscillator choice settle before counting.
         repeat (400) @(posedge clk_i);
         t = 0;
         for (int n = 0; n < 400; n++) begin
            rq[1] = mtc;
            @(posedge clk_i);
            t += (mtc !== rq[1]);
         end
         near("osc_ticks", (c == 0) ? 80 : (100 >> (c - 1)), t, 2);
      end
      // The last two rounds stay idle, so no driver wakes without the idle wait.
      for (int k = 0; k < 10; k++) begin
         send(19'($urandom & 19'h0_FFFE | ((k < 8) ? 19'h4_0001 : 19'h0_0001)));
         send(19'($urandom & 19'h7_FFFE));
         check_cfg();
         if (k > 7) begin
            sleep_n <= (k != 8) ? 1'b1 : 1'b0;
            uvlo <= (k == 9);
            repeat (3) @(posedge clk_i);
            sleep_n <= 1'b1;
            uvlo <= 1'b0;
            repeat (1000) @(posedge clk_i);
            w0 = 19'h0_0000;
            w1 = 19'h0_0000;
            check_cfg();
         end
      end
      close_out();
   end
endmodule
`default_nettype wire
